// ==== hdl/host_port_pkg.sv ====
// constants for the host serial port control block
package host_port_pkg;
	localparam int unsigned CLK_HZ           = 20_000_000;
	localparam int unsigned STRAP_WINDOW_MS  = 20;
	localparam int unsigned WAKE_MS          = 20;
	localparam int unsigned BUSY_DELAY_US    = 2;
	localparam int unsigned BYTE_GAP_US      = 3;
	localparam int unsigned STRAP_CYCLES     = CLK_HZ / 1000 * STRAP_WINDOW_MS / 2;
	localparam int unsigned WAKE_CYCLES      = CLK_HZ / 1000 * WAKE_MS / 2;
	localparam int unsigned BUSY_DLY_CYCLES  = (CLK_HZ / 1_000_000) * BUSY_DELAY_US;
	localparam int unsigned BYTE_BITS        = 8;
	localparam logic [7:0]  MISO_IDLE_BYTE   = 8'hFF;
	localparam logic        PORT_SEL_UART    = 1'b0;
	localparam logic        PORT_SEL_SPI     = 1'b1;
	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_STRAP = 5'h02,
		ST_READY = 5'h04,
		ST_BUSY  = 5'h08,
		ST_SLEEP = 5'h10
	} port_state_t;
endpackage : host_port_pkg

// ==== hdl/host_serial_port_control.sv ====
// host serial port control: strap select, spi slave shifter, busy, irq, sleep, reset pin
`timescale 1ns/100ps
module host_serial_port_control
	import host_port_pkg::*;
#(
	parameter int unsigned STRAP_CNT = STRAP_CYCLES,
	parameter int unsigned WAKE_CNT  = WAKE_CYCLES
) (
	input  wire logic       CLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       RESET_PIN_I,
	output logic            RESET_PIN_O,
	output logic            RESET_PIN_OE_O,
	input  wire logic       INT_RESET_REQ_I,
	input  wire logic       INTERFACE_SELECT_STRAP_I,
	input  wire logic       SCLK_I,
	input  wire logic       SSEL_N_I,
	input  wire logic       MOSI_I,
	output logic            MISO_O,
	output logic            MISO_OE_O,
	input  wire logic [7:0] TX_BYTE_I,
	output logic            TX_BYTE_TAKEN_O,
	output logic [7:0]      RX_BYTE_O,
	output logic            RX_BYTE_VALID_O,
	input  wire logic       MSG_DONE_I,
	output logic            BUSY_O,
	input  wire logic       IRQ_EVENT_I,
	input  wire logic       IRQ_CLEAR_I,
	output logic            IRQ_N_O,
	output logic            IRQ_OE_O,
	input  wire logic       SLEEP_N_I,
	output logic            LOW_POWER_O,
	output logic            SPI_SEL_O,
	output logic            UART_EN_O
);
	import host_port_pkg::*;

	port_state_t       state_reg, state_next;
	logic [22:0]       cnt_reg;
	logic              sclk_d_reg, ssel_d_reg;
	logic [2:0]        bit_reg;
	logic [7:0]        rx_sh_reg, tx_sh_reg;
	logic              irq_pend_reg;
	logic              int_rst_reg;
	logic [6:0]        rel_age_reg;
	logic              msg_seen_reg;

	// pin value is read on the clock; reset source combined with our own drive ignored
	wire ext_reset   = ~RESET_PIN_I & ~int_rst_reg;
	wire selected    = ~SSEL_N_I & (state_reg == ST_READY) & SPI_SEL_O;
	wire sclk_rise   = selected & SCLK_I & ~sclk_d_reg;
	wire sclk_fall   = selected & ~SCLK_I & sclk_d_reg;
	// select edges count only in spi mode; a falling edge only when ready
	wire ssel_fall   = selected & ssel_d_reg;
	wire ssel_rise   = SSEL_N_I & ~ssel_d_reg & SPI_SEL_O;
	wire byte_done   = sclk_rise & (bit_reg == 3'(BYTE_BITS - 1));
	wire cnt_done    = (cnt_reg == 23'd0);
	wire soft_reset  = INT_RESET_REQ_I | ext_reset;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RESET: state_next = ST_STRAP;
			ST_STRAP: if (cnt_done) state_next = ST_READY;
			ST_READY: if (!SLEEP_N_I) state_next = ST_SLEEP;
			          else if (msg_seen_reg && cnt_done) state_next = ST_BUSY;
			ST_BUSY:  if (!SLEEP_N_I) state_next = ST_SLEEP;
			          else if (MSG_DONE_I) state_next = ST_READY;
			ST_SLEEP: if (SLEEP_N_I && cnt_done) state_next = ST_READY;
			default:  state_next = ST_RESET;
		endcase
		if (soft_reset) state_next = ST_RESET;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg <= ST_RESET;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			if (state_next == ST_STRAP && state_reg != ST_STRAP)
				cnt_reg <= 23'(STRAP_CNT);
			else if (state_reg == ST_SLEEP && !SLEEP_N_I)
				cnt_reg <= 23'(WAKE_CNT);
			else if (state_reg == ST_READY && ssel_rise)
				cnt_reg <= 23'(BUSY_DLY_CYCLES - 1);
			else if (!cnt_done)
				cnt_reg <= cnt_reg - 23'd1;
		end
	end

	// strap caught by a clocked step at the end of the window, not by the reset
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SPI_SEL_O <= PORT_SEL_UART;
			UART_EN_O <= 1'b0;
		end else if (state_reg == ST_STRAP && cnt_done) begin
			SPI_SEL_O <= INTERFACE_SELECT_STRAP_I;
			UART_EN_O <= ~INTERFACE_SELECT_STRAP_I;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sclk_d_reg <= 1'b0;
			ssel_d_reg <= 1'b1;
		end else begin
			sclk_d_reg <= SCLK_I;
			ssel_d_reg <= SSEL_N_I;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			bit_reg         <= '0;
			rx_sh_reg       <= '0;
			tx_sh_reg       <= MISO_IDLE_BYTE;
			RX_BYTE_O       <= '0;
			RX_BYTE_VALID_O <= 1'b0;
			TX_BYTE_TAKEN_O <= 1'b0;
			MISO_O          <= 1'b1;
		end else begin
			RX_BYTE_VALID_O <= byte_done;
			TX_BYTE_TAKEN_O <= 1'b0;
			if (ssel_fall) begin
				bit_reg   <= '0;
				tx_sh_reg <= TX_BYTE_I;
				MISO_O    <= TX_BYTE_I[7];
				TX_BYTE_TAKEN_O <= 1'b1;
			end else begin
				if (sclk_rise) begin
					rx_sh_reg <= {rx_sh_reg[6:0], MOSI_I};
					bit_reg   <= bit_reg + 3'd1;
				end
				if (byte_done)
					RX_BYTE_O <= {rx_sh_reg[6:0], MOSI_I};
				if (sclk_fall) begin
					// byte boundary reached on the last rise: reload next byte
					if (bit_reg == 3'd0) begin
						tx_sh_reg <= TX_BYTE_I;
						MISO_O    <= TX_BYTE_I[7];
						TX_BYTE_TAKEN_O <= 1'b1;
					end else begin
						tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
						MISO_O    <= tx_sh_reg[6];
					end
				end
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			msg_seen_reg   <= 1'b0;
			BUSY_O         <= 1'b0;
			MISO_OE_O      <= 1'b0;
			LOW_POWER_O    <= 1'b0;
			irq_pend_reg   <= 1'b0;
			IRQ_N_O        <= 1'b0;
			IRQ_OE_O       <= 1'b0;
			int_rst_reg    <= 1'b0;
			RESET_PIN_O    <= 1'b0;
			RESET_PIN_OE_O <= 1'b0;
		end else begin
			if (state_reg == ST_READY && ssel_rise)
				msg_seen_reg <= 1'b1;
			else if (state_next == ST_BUSY || state_next == ST_RESET)
				msg_seen_reg <= 1'b0;
			BUSY_O      <= (state_next == ST_BUSY) | (state_next == ST_STRAP)
			             | (state_next == ST_RESET);
			MISO_OE_O   <= ~SSEL_N_I & SPI_SEL_O & (state_next == ST_READY);
			LOW_POWER_O <= (state_next == ST_SLEEP);
			// a new event beats a clear in the same cycle
			irq_pend_reg <= IRQ_EVENT_I | (irq_pend_reg & ~IRQ_CLEAR_I);
			IRQ_OE_O     <= IRQ_EVENT_I | (irq_pend_reg & ~IRQ_CLEAR_I);
			if (INT_RESET_REQ_I)
				int_rst_reg <= 1'b1;
			else if (state_reg == ST_STRAP)
				int_rst_reg <= 1'b0;
			RESET_PIN_OE_O <= INT_RESET_REQ_I | (int_rst_reg & state_reg != ST_STRAP);
		end
	end

	// cycles since the last select release seen in ready, saturating; only the busy delay check reads it
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			rel_age_reg <= '0;
		else if (state_reg == ST_READY && ssel_rise)
			rel_age_reg <= 7'h01;
		else if (rel_age_reg != 7'h7F)
			rel_age_reg <= rel_age_reg + 7'h01;
	end

	a_busy_after_ssel: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(state_reg == ST_READY && ssel_rise && SLEEP_N_I && !soft_reset)
		|-> !BUSY_O [*2]) else $error("busy rose too soon after select release");
	// the short check above cannot see the whole delay; this one does
	a_busy_delay: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(state_reg == ST_BUSY && $past(state_reg) == ST_READY)
		|-> rel_age_reg > 7'(BUSY_DLY_CYCLES))
		else $error("busy rose before the release delay");
	a_miso_released: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		SSEL_N_I |=> !MISO_OE_O) else $error("miso driven while deselected");
	a_irq_drive: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		IRQ_EVENT_I |=> IRQ_OE_O && !IRQ_N_O) else $error("irq not driven low");
	a_sleep_enter: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(!SLEEP_N_I && state_reg != ST_RESET && state_reg != ST_STRAP && !soft_reset)
		|=> LOW_POWER_O) else $error("sleep not entered");
	a_ssel_clears: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		ssel_fall |=> bit_reg == 3'd0) else $error("bit counter not cleared");
	a_rx_capture: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(sclk_rise && !ssel_fall) |=> rx_sh_reg[0] == $past(MOSI_I))
		else $error("mosi bit not captured");
	a_busy_clears: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(state_reg == ST_BUSY && MSG_DONE_I && SLEEP_N_I && !soft_reset)
		|=> !BUSY_O) else $error("busy stayed high after done");
	a_int_reset_pin: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		INT_RESET_REQ_I |=> RESET_PIN_OE_O && !RESET_PIN_O)
		else $error("reset pin not driven on internal reset");
	a_strap_mode: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(state_reg == ST_STRAP && cnt_done && !soft_reset)
		|=> SPI_SEL_O == $past(INTERFACE_SELECT_STRAP_I) && UART_EN_O != SPI_SEL_O)
		else $error("strap not applied");
endmodule : host_serial_port_control

// ==== verification/spi_host_model.sv ====
// spi master standing in for the host processor
`timescale 1ns/100ps
module spi_host_model
	import host_port_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic miso_i,
	output logic      sclk_o,
	output logic      ssel_n_o,
	output logic      mosi_o
);
	// byte gap kept before every select, so back-to-back calls stay legal
	localparam int unsigned GAP_CYCLES = (CLK_HZ / 1_000_000) * BYTE_GAP_US;
	initial begin
		sclk_o   = 1'b0;
		ssel_n_o = 1'b1;
		mosi_o   = 1'b0;
	end
	// four cycles a phase, over the two the slave needs; call at a clock edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		repeat (GAP_CYCLES) @(posedge clk_i);
		ssel_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int i = 7; i >= 0; i--) begin
			mosi_o <= tx[i];
			repeat (4) @(posedge clk_i);
			rx[i] = miso_i;
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		ssel_n_o <= 1'b1;
		// released data line must not keep looking valid
		mosi_o   <= ~mosi_o;
	endtask : xfer
endmodule : spi_host_model

// ==== verification/testbench.sv ====
// self-checking bench for the host serial port control block
`timescale 1ns/100ps
module testbench;
	import host_port_pkg::*;
	logic       clk, rst_n, ext_rst_n, reset_pin, rp_o, rp_oe, int_rst, strap;
	logic       sclk, ssel_n, mosi, miso, miso_oe, tx_taken, rx_valid, msg_done, busy;
	logic       irq_ev, irq_clr, irq_n, irq_oe, sleep_n, low_power, spi_sel, uart_en;
	logic [7:0] tx_byte, rx_byte, rx;
	int         errors, check_count, n;
	int         rx_pulses = 0;
	int         tx_pulses = 0;
	logic       miso_line;
	// a released data line reads as the inverse, so a late sample shows up
	assign miso_line = miso_oe ? miso : ~miso;
	always @(posedge clk) begin
		if (rx_valid === 1'b1)
			rx_pulses <= rx_pulses + 1;
		if (tx_taken === 1'b1)
			tx_pulses <= tx_pulses + 1;
	end
	// open-drain reset wire with pull-up
	assign reset_pin = ext_rst_n & (rp_oe ? rp_o : 1'b1);
	spi_host_model host (.clk_i(clk), .miso_i(miso_line), .sclk_o(sclk), .ssel_n_o(ssel_n),
		.mosi_o(mosi));
	host_serial_port_control #(.STRAP_CNT(4), .WAKE_CNT(4)) dut (
		.CLK_I(clk), .RST_N_I(rst_n), .RESET_PIN_I(reset_pin), .RESET_PIN_O(rp_o),
		.RESET_PIN_OE_O(rp_oe), .INT_RESET_REQ_I(int_rst), .INTERFACE_SELECT_STRAP_I(strap),
		.SCLK_I(sclk), .SSEL_N_I(ssel_n), .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(miso_oe),
		.TX_BYTE_I(tx_byte), .TX_BYTE_TAKEN_O(tx_taken), .RX_BYTE_O(rx_byte),
		.RX_BYTE_VALID_O(rx_valid), .MSG_DONE_I(msg_done), .BUSY_O(busy),
		.IRQ_EVENT_I(irq_ev), .IRQ_CLEAR_I(irq_clr), .IRQ_N_O(irq_n), .IRQ_OE_O(irq_oe),
		.SLEEP_N_I(sleep_n), .LOW_POWER_O(low_power), .SPI_SEL_O(spi_sel), .UART_EN_O(uart_en));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	// counts cycles until busy shows v; a hang ends the run
	task automatic wait_busy(input logic v, output int cnt);
		cnt = 0;
		while (busy !== v) begin
			if (cnt == 1000) begin
				errors++;
				tally_and_finish;
			end
			@(posedge clk);
			cnt++;
		end
	endtask : wait_busy
	task automatic t_spi_byte;
		int rx0, tx0;
		rx0 = rx_pulses;
		tx0 = tx_pulses;
		wait_busy(1'b0, n);
		tx_byte <= 8'hA5;
		host.xfer(8'h3C, rx);
		check(rx_byte, 8'h3C);
		check(rx, 8'hA5);
		check(8'(rx_pulses - rx0), 8'h01);
		check(8'(tx_pulses - tx0), 8'h02);
		repeat (2) @(posedge clk);
		check(miso_oe, 1'b0);
		wait_busy(1'b1, n);
		// busy is seen one edge after it rises; release was two edges before counting
		check(n + 1 >= BUSY_DLY_CYCLES, 1'b1);
		check(busy, 1'b1);
		msg_done <= 1'b1;
		@(posedge clk);
		msg_done <= 1'b0;
		@(posedge clk);
		check(busy, 1'b0);
	endtask : t_spi_byte
	task automatic t_irq;
		irq_ev <= 1'b1;
		@(posedge clk);
		irq_ev <= 1'b0;
		@(posedge clk);
		check({irq_oe, irq_n}, 8'h2);
		@(posedge clk);
		check(irq_oe, 1'b1);
		// event and clear together: the event wins
		irq_ev  <= 1'b1;
		irq_clr <= 1'b1;
		@(posedge clk);
		irq_ev <= 1'b0;
		@(posedge clk);
		check(irq_oe, 1'b1);
		irq_clr <= 1'b0;
		@(posedge clk);
		check(irq_oe, 1'b0);
	endtask : t_irq
	task automatic t_sleep;
		sleep_n <= 1'b0;
		repeat (2) @(posedge clk);
		check(low_power, 1'b1);
		sleep_n <= 1'b1;
		repeat (12) @(posedge clk);
		check(low_power, 1'b0);
	endtask : t_sleep
	// internal reset, strap now low: uart chosen, spi traffic ignored
	task automatic t_int_reset;
		strap   <= 1'b0;
		int_rst <= 1'b1;
		@(posedge clk);
		int_rst <= 1'b0;
		for (n = 0; n < 10 && rp_oe !== 1'b1; n++)
			@(posedge clk);
		check(rp_oe, 1'b1);
		wait_busy(1'b0, n);
		check(rp_oe, 1'b0);
		check({uart_en, spi_sel}, 8'h2);
		n = rx_pulses + tx_pulses;
		host.xfer(8'hC3, rx);
		check(rx_byte, 8'h3C);
		check(8'(rx_pulses + tx_pulses - n), 8'h00);
		// a select release in uart mode must not start the busy delay
		repeat (BUSY_DLY_CYCLES + 5) @(posedge clk);
		check(busy, 1'b0);
	endtask : t_int_reset
	// pin pulled low from outside: full restart, pin left to the outside source
	task automatic t_ext_reset;
		strap     <= 1'b1;
		ext_rst_n <= 1'b0;
		@(posedge clk);
		ext_rst_n <= 1'b1;
		wait_busy(1'b1, n);
		check(rp_oe, 1'b0);
		wait_busy(1'b0, n);
		check({uart_en, spi_sel}, 8'h1);
	endtask : t_ext_reset
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rst_n, int_rst, tx_byte, msg_done, irq_ev, irq_clr} = '0;
		{ext_rst_n, strap, sleep_n} = 3'b111;
		errors = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// busy still shows its reset value here: see it rise first
		wait_busy(1'b1, n);
		check(busy, 1'b1);
		wait_busy(1'b0, n);
		check({uart_en, spi_sel}, 8'h1);
		t_spi_byte;
		t_irq;
		t_sleep;
		t_int_reset;
		t_ext_reset;
		tally_and_finish;
	end
endmodule : testbench
